// *** shared/irq_ctrl_pkg.sv ***
// constants for the phone interrupt controller
package irq_ctrl_pkg;
    // register indices; each register is one aligned word
    localparam logic [7:0] IDX_PRIMARY    = 8'h0b;
    localparam logic [7:0] IDX_SECONDARY  = 8'h1e;
    // apb byte addresses, four times the index
    localparam logic [7:0] ADDR_PRIMARY   = {IDX_PRIMARY[5:0], 2'b00};
    localparam logic [7:0] ADDR_SECONDARY = {IDX_SECONDARY[5:0], 2'b00};
    // primary register fields
    localparam int BIT_GLOBAL_EN  = 0;
    localparam int BIT_EXT_EN     = 1;
    localparam int BIT_TMR0_EN    = 2;
    localparam int BIT_TMR1_EN    = 3;
    localparam int BIT_EXT_PEND   = 4;
    localparam int BIT_TMR0_PEND  = 5;
    localparam int BIT_TMR1_PEND  = 6;
    // secondary register fields
    localparam int BIT_RSV0       = 0;
    localparam int BIT_RTC_EN     = 1;
    localparam int BIT_DIALER_EN  = 2;
    localparam int BIT_RSV4       = 4;
    localparam int BIT_RTC_PEND   = 5;
    localparam int BIT_DIALER_PEND = 6;
    // reset values
    localparam logic [7:0] RESET_PRIMARY   = 8'h00;
    localparam logic [7:0] RESET_SECONDARY = 8'h00;
    // vectors
    localparam logic [7:0] VEC_EXT    = 8'h04;
    localparam logic [7:0] VEC_TMR0   = 8'h08;
    localparam logic [7:0] VEC_TMR1   = 8'h0c;
    localparam logic [7:0] VEC_RTC    = 8'h14;
    localparam logic [7:0] VEC_DIALER = 8'h18;
    localparam logic [7:0] VEC_NONE   = 8'h00;
    // source index order is priority order
    localparam int NUM_SRC = 5;
    localparam int SRC_EXT = 0;
    localparam int SRC_TMR0 = 1;
    localparam int SRC_TMR1 = 2;
    localparam int SRC_RTC = 3;
    localparam int SRC_DIALER = 4;
endpackage

// *** hdl/edge_sync.sv ***
// two-flop synchroniser with registered previous value for edge detection
`timescale 1ns/1ps
`default_nettype none
module edge_sync #(
    parameter logic RESET_LEVEL = 1'b1
) (
    input  wire logic sys_clk,   // system clock
    input  wire logic rst_sync_n, // synchronised reset
    input  wire logic pin_in,    // asynchronous pin
    output logic      level_out, // synchronised level
    output logic      rise_out,  // one-cycle rising pulse
    output logic      fall_out   // one-cycle falling pulse
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            meta_q <= RESET_LEVEL;
            sync_q <= RESET_LEVEL;
            prev_q <= RESET_LEVEL;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_out = sync_q;
    assign rise_out  = sync_q & ~prev_q;
    assign fall_out  = ~sync_q & prev_q;
endmodule
`default_nettype wire

// *** hdl/irq_controller.sv ***
// interrupt controller with two control registers on apb
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module irq_controller (
    input  wire logic        sys_clk,         // 50 mhz system clock
    input  wire logic        rst_n,           // async reset, active low
    input  wire logic        psel,            // apb select
    input  wire logic        penable,         // apb enable
    input  wire logic        pwrite,          // apb direction
    input  wire logic [7:0]  paddr,           // apb byte address
    input  wire logic [31:0] pwdata,          // apb write data
    output logic             pready,          // apb ready
    output logic [31:0]      prdata,          // apb read data
    output logic             pslverr,         // apb error
    input  wire logic        ext_irq_pin,     // external interrupt pin
    input  wire logic        hook_switch_in,  // hook switch pin
    input  wire logic        hold_line_in,    // hold line pin
    input  wire logic        handsfree_in,    // handsfree pin
    input  wire logic        tmr0_overflow,   // timer0 overflow pulse
    input  wire logic        tmr1_overflow,   // timer1 overflow pulse
    input  wire logic        rtc_tick,        // 1hz rtc pulse
    input  wire logic        on_hook_status,  // dialer on-hook status
    input  wire logic        hold_status,     // dialer hold-line status
    input  wire logic        idle_mode,       // controller in idle mode
    input  wire logic        phase_two_tick,  // phase-two pulse
    input  wire logic        stack_full,      // return stack full
    input  wire logic        core_ready,      // core can take a call now
    input  wire logic        return_from_irq, // return executed pulse
    output logic             irq_ack,         // acknowledge pulse
    output logic [7:0]       irq_vector,      // branch vector
    output logic             push_pc          // push program counter only
);
    // ****************************************************************
    // reset release
    // ****************************************************************
    // the rest of the block leaves reset two edges after rst_n rises
    logic rst_meta_q;
    logic rst_sync_n;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_n <= rst_meta_q;
        end
    end

    // ****************************************************************
    // pin synchronisers and edges
    // ****************************************************************
    logic ext_fall;
    logic hook_rise;
    logic hook_fall;
    logic hold_fall;
    logic hf_rise;

    // pins idle at their reset level, so no false edge after reset
    edge_sync #(.RESET_LEVEL(1'b1)) u_ext (
        .sys_clk    (sys_clk),
        .rst_sync_n (rst_sync_n),
        .pin_in     (ext_irq_pin),
        .level_out  (),
        .rise_out   (),
        .fall_out   (ext_fall)
    );
    edge_sync #(.RESET_LEVEL(1'b1)) u_hook (
        .sys_clk    (sys_clk),
        .rst_sync_n (rst_sync_n),
        .pin_in     (hook_switch_in),
        .level_out  (),
        .rise_out   (hook_rise),
        .fall_out   (hook_fall)
    );
    edge_sync #(.RESET_LEVEL(1'b1)) u_hold (
        .sys_clk    (sys_clk),
        .rst_sync_n (rst_sync_n),
        .pin_in     (hold_line_in),
        .level_out  (),
        .rise_out   (),
        .fall_out   (hold_fall)
    );
    edge_sync #(.RESET_LEVEL(1'b0)) u_hf (
        .sys_clk    (sys_clk),
        .rst_sync_n (rst_sync_n),
        .pin_in     (handsfree_in),
        .level_out  (),
        .rise_out   (hf_rise),
        .fall_out   ()
    );

    // ****************************************************************
    // source events
    // ****************************************************************
    logic [irq_ctrl_pkg::NUM_SRC-1:0] hw_set;

    always_comb begin
        hw_set[irq_ctrl_pkg::SRC_EXT]    = ext_fall;
        hw_set[irq_ctrl_pkg::SRC_TMR0]   = tmr0_overflow;
        hw_set[irq_ctrl_pkg::SRC_TMR1]   = tmr1_overflow;
        hw_set[irq_ctrl_pkg::SRC_RTC]    = rtc_tick;
        hw_set[irq_ctrl_pkg::SRC_DIALER] = ~idle_mode & (hook_rise | hook_fall | hf_rise
                                           | (hold_fall & ~(on_hook_status & hold_status)));
    end

    // ****************************************************************
    // register state
    // ****************************************************************
    logic                             global_irq_enable_q, global_irq_enable_d;
    logic [irq_ctrl_pkg::NUM_SRC-1:0] src_en_q, src_en_d;
    logic [irq_ctrl_pkg::NUM_SRC-1:0] pend_q, pend_d;
    logic [1:0]                       rsv_q, rsv_d;
    logic                             ack_q, ack_d;
    logic [7:0]                       vec_q, vec_d;
    logic [31:0]                      rdata_q, rdata_d;

    logic hit_pri;
    logic hit_sec;
    logic wr_pri;
    logic wr_sec;
    logic rd_acc;
    logic [7:0] primary_view;
    logic [7:0] secondary_view;
    logic [irq_ctrl_pkg::NUM_SRC-1:0] req;
    logic [irq_ctrl_pkg::NUM_SRC-1:0] grant;
    logic take;

    function automatic logic [7:0] vec_of(input logic [irq_ctrl_pkg::NUM_SRC-1:0] g);
        logic [7:0] v;
        v = irq_ctrl_pkg::VEC_NONE;
        if (g[irq_ctrl_pkg::SRC_EXT])         v = irq_ctrl_pkg::VEC_EXT;
        else if (g[irq_ctrl_pkg::SRC_TMR0])   v = irq_ctrl_pkg::VEC_TMR0;
        else if (g[irq_ctrl_pkg::SRC_TMR1])   v = irq_ctrl_pkg::VEC_TMR1;
        else if (g[irq_ctrl_pkg::SRC_RTC])    v = irq_ctrl_pkg::VEC_RTC;
        else if (g[irq_ctrl_pkg::SRC_DIALER]) v = irq_ctrl_pkg::VEC_DIALER;
        return v;
    endfunction

    // exact byte-address match on each control register
    assign hit_pri = (paddr == irq_ctrl_pkg::ADDR_PRIMARY);
    assign hit_sec = (paddr == irq_ctrl_pkg::ADDR_SECONDARY);
    // writes land in the access phase only
    assign wr_pri  = psel & penable & pwrite & hit_pri;
    assign wr_sec  = psel & penable & pwrite & hit_sec;
    // read data captured in the setup phase
    assign rd_acc  = psel & ~penable & ~pwrite;

    always_comb begin
        req = pend_q & src_en_q & {irq_ctrl_pkg::NUM_SRC{global_irq_enable_q}};
        req[irq_ctrl_pkg::SRC_DIALER] = req[irq_ctrl_pkg::SRC_DIALER] & ~idle_mode;
        grant = req & (~req + 1'b1);
        take = phase_two_tick & ~stack_full & core_ready & (|req);
    end

    always_comb begin
        global_irq_enable_d = global_irq_enable_q;
        src_en_d = src_en_q;
        pend_d   = pend_q;
        rsv_d    = rsv_q;
        if (wr_pri) begin
            global_irq_enable_d = pwdata[irq_ctrl_pkg::BIT_GLOBAL_EN];
            src_en_d[irq_ctrl_pkg::SRC_EXT]  = pwdata[irq_ctrl_pkg::BIT_EXT_EN];
            src_en_d[irq_ctrl_pkg::SRC_TMR0] = pwdata[irq_ctrl_pkg::BIT_TMR0_EN];
            src_en_d[irq_ctrl_pkg::SRC_TMR1] = pwdata[irq_ctrl_pkg::BIT_TMR1_EN];
            pend_d[irq_ctrl_pkg::SRC_EXT]    = pwdata[irq_ctrl_pkg::BIT_EXT_PEND];
            pend_d[irq_ctrl_pkg::SRC_TMR0]   = pwdata[irq_ctrl_pkg::BIT_TMR0_PEND];
            pend_d[irq_ctrl_pkg::SRC_TMR1]   = pwdata[irq_ctrl_pkg::BIT_TMR1_PEND];
        end
        if (wr_sec) begin
            src_en_d[irq_ctrl_pkg::SRC_RTC]    = pwdata[irq_ctrl_pkg::BIT_RTC_EN];
            src_en_d[irq_ctrl_pkg::SRC_DIALER] = pwdata[irq_ctrl_pkg::BIT_DIALER_EN];
            pend_d[irq_ctrl_pkg::SRC_RTC]      = pwdata[irq_ctrl_pkg::BIT_RTC_PEND];
            pend_d[irq_ctrl_pkg::SRC_DIALER]   = pwdata[irq_ctrl_pkg::BIT_DIALER_PEND];
            rsv_d = {pwdata[irq_ctrl_pkg::BIT_RSV4], pwdata[irq_ctrl_pkg::BIT_RSV0]};
        end
        if (return_from_irq) begin
            global_irq_enable_d = 1'b1;
        end
        // clear granted flag and global enable
        if (take) begin
            pend_d = pend_d & ~grant;
            global_irq_enable_d = 1'b0;
        end
        pend_d = pend_d | hw_set;
    end

    // ****************************************************************
    // register read views
    // ****************************************************************
    always_comb begin
        primary_view   = 8'h00;
        secondary_view = 8'h00;
        primary_view[irq_ctrl_pkg::BIT_GLOBAL_EN] = global_irq_enable_q;
        primary_view[irq_ctrl_pkg::BIT_EXT_EN]    = src_en_q[irq_ctrl_pkg::SRC_EXT];
        primary_view[irq_ctrl_pkg::BIT_TMR0_EN]   = src_en_q[irq_ctrl_pkg::SRC_TMR0];
        primary_view[irq_ctrl_pkg::BIT_TMR1_EN]   = src_en_q[irq_ctrl_pkg::SRC_TMR1];
        // flags above, bit 7 left zero
        primary_view[irq_ctrl_pkg::BIT_EXT_PEND]  = pend_q[irq_ctrl_pkg::SRC_EXT];
        primary_view[irq_ctrl_pkg::BIT_TMR0_PEND] = pend_q[irq_ctrl_pkg::SRC_TMR0];
        primary_view[irq_ctrl_pkg::BIT_TMR1_PEND] = pend_q[irq_ctrl_pkg::SRC_TMR1];
        // bits 3 and 7 left zero
        secondary_view[irq_ctrl_pkg::BIT_RSV0]        = rsv_q[0];
        secondary_view[irq_ctrl_pkg::BIT_RTC_EN]      = src_en_q[irq_ctrl_pkg::SRC_RTC];
        secondary_view[irq_ctrl_pkg::BIT_DIALER_EN]   = src_en_q[irq_ctrl_pkg::SRC_DIALER];
        secondary_view[irq_ctrl_pkg::BIT_RSV4]        = rsv_q[1];
        secondary_view[irq_ctrl_pkg::BIT_RTC_PEND]    = pend_q[irq_ctrl_pkg::SRC_RTC];
        secondary_view[irq_ctrl_pkg::BIT_DIALER_PEND] = pend_q[irq_ctrl_pkg::SRC_DIALER];
    end

    always_comb begin
        ack_d = take;
        vec_d = take ? vec_of(grant) : vec_q;
    end

    always_comb begin
        rdata_d = rdata_q;
        // unmapped reads return zero
        if (rd_acc) begin
            rdata_d = 32'h0000_0000;
            if (hit_pri) begin
                rdata_d = {24'h00_0000, primary_view};
            end else if (hit_sec) begin
                rdata_d = {24'h00_0000, secondary_view};
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            global_irq_enable_q <= irq_ctrl_pkg::RESET_PRIMARY[irq_ctrl_pkg::BIT_GLOBAL_EN];
            src_en_q <= '0;
            pend_q   <= '0;
            rsv_q    <= '0;
            ack_q    <= 1'b0;
            vec_q    <= irq_ctrl_pkg::VEC_NONE;
            rdata_q  <= 32'h0000_0000;
        end else begin
            global_irq_enable_q <= global_irq_enable_d;
            src_en_q <= src_en_d;
            pend_q   <= pend_d;
            rsv_q    <= rsv_d;
            ack_q    <= ack_d;
            vec_q    <= vec_d;
            rdata_q  <= rdata_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit_pri & ~hit_sec;
    assign prdata  = rdata_q;
    assign irq_ack = ack_q;
    assign irq_vector = vec_q;
    assign push_pc = ack_q;
endmodule
`default_nettype wire

// *** dv/irq_controller_props.sv ***
// concurrent checks on the interrupt controller ports
`timescale 1ns/1ps
`default_nettype none
module irq_controller_props (
    input wire logic        sys_clk,         // clock
    input wire logic        rst_n,           // reset
    input wire logic        psel,            // select
    input wire logic        penable,         // enable
    input wire logic        pwrite,          // direction
    input wire logic [7:0]  paddr,           // address
    input wire logic        pready,          // ready
    input wire logic [31:0] prdata,          // read data
    input wire logic        stack_full,      // stack full
    input wire logic        phase_two_tick,  // tick
    input wire logic        return_from_irq, // return
    input wire logic        irq_ack,         // ack
    input wire logic [7:0]  irq_vector,      // vector
    input wire logic        push_pc          // push
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    wire logic rd_pri;
    wire logic rd_sec;
    assign rd_pri = psel && penable && !pwrite && paddr == irq_ctrl_pkg::ADDR_PRIMARY;
    assign rd_sec = psel && penable && !pwrite && paddr == irq_ctrl_pkg::ADDR_SECONDARY;
    sequence s_quiet;
        !return_from_irq && !psel;
    endsequence
    sequence s_taken;
        irq_ack && !return_from_irq && !psel && !$past(psel);
    endsequence
    property p_ready; psel && penable |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("access not ready");
    property p_rd_pri; rd_pri |-> prdata[31:7] == 25'h0; endproperty
    a_rd_pri: assert property (p_rd_pri) else $error("primary unused bits set");
    property p_rd_sec; rd_sec |-> prdata[31:7] == 25'h0 && !prdata[3]; endproperty
    a_rd_sec: assert property (p_rd_sec) else $error("secondary unused bits set");
    property p_push; irq_ack || push_pc |-> irq_ack && push_pc; endproperty
    a_push: assert property (p_push) else $error("push and ack differ");
    property p_tick; irq_ack |-> $past(phase_two_tick); endproperty
    a_tick: assert property (p_tick) else $error("ack without tick");
    property p_stack; irq_ack |-> !$past(stack_full); endproperty
    a_stack: assert property (p_stack) else $error("ack while stack full");
    property p_vec; irq_ack |-> irq_vector inside {8'h04, 8'h08, 8'h0c, 8'h14, 8'h18}; endproperty
    a_vec: assert property (p_vec) else $error("bad vector");
    property p_hold; !irq_ack |-> $stable(irq_vector); endproperty
    a_hold: assert property (p_hold) else $error("vector moved without ack");
    property p_pulse; irq_ack |=> !irq_ack; endproperty
    a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
    property p_quiet; s_taken ##1 s_quiet [*2] |=> !irq_ack; endproperty
    a_quiet: assert property (p_quiet) else $error("ack without re-enable");
endmodule
bind irq_controller irq_controller_props props (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
    .stack_full(stack_full), .phase_two_tick(phase_two_tick), .irq_ack(irq_ack),
    .return_from_irq(return_from_irq), .irq_vector(irq_vector), .push_pc(push_pc));
`default_nettype wire

// *** dv/core_model.sv ***
// core sequencer model: phase ticks and return after service
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input  wire logic       sys_clk,         // clock
    input  wire logic       rst_n,           // reset
    input  wire logic       irq_ack,         // ack from block
    input  wire logic       ret_en,          // return after service
    input  wire logic [3:0] ret_delay,       // service length
    output logic            phase_two_tick,  // phase pulse
    output logic            return_from_irq  // return pulse
);
    logic [1:0] phase_q;
    logic [3:0] wait_q;
    logic       busy_q;
    assign phase_two_tick = (phase_q == 2'h3);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= 2'h0;
            wait_q <= 4'h0;
            busy_q <= 1'b0;
            return_from_irq <= 1'b0;
        end else begin
            phase_q <= phase_q + 2'h1;
            return_from_irq <= 1'b0;
            if (irq_ack && ret_en) begin
                busy_q <= 1'b1;
                wait_q <= ret_delay;
            end else if (busy_q && wait_q == 4'h0) begin
                busy_q <= 1'b0;
                return_from_irq <= 1'b1;
            end else if (busy_q) begin
                wait_q <= wait_q - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, err, ret_en;
    logic ext_irq_pin, hook_switch_in, hold_line_in, handsfree_in, on_hook_status;
    logic tmr0_overflow, tmr1_overflow, rtc_tick, hold_status, idle_mode;
    logic phase_two_tick, stack_full, return_from_irq, irq_ack, push_pc;
    logic [7:0] paddr, irq_vector;
    logic [31:0] pwdata, prdata, rd, d;
    logic [3:0] ret_delay;
    int miscompares = 0, checks = 0, cycles = 0;
    localparam logic [7:0] PRI = irq_ctrl_pkg::ADDR_PRIMARY;
    localparam logic [7:0] SEC = irq_ctrl_pkg::ADDR_SECONDARY;
    logic [7:0] vecs [5] = '{8'h04, 8'h08, 8'h0c, 8'h14, 8'h18};
    irq_controller uut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .ext_irq_pin(ext_irq_pin), .hook_switch_in(hook_switch_in),
        .hold_line_in(hold_line_in), .handsfree_in(handsfree_in), .rtc_tick(rtc_tick),
        .tmr0_overflow(tmr0_overflow), .tmr1_overflow(tmr1_overflow), .idle_mode(idle_mode),
        .on_hook_status(on_hook_status), .hold_status(hold_status), .stack_full(stack_full),
        .phase_two_tick(phase_two_tick), .core_ready(1'b1), .irq_ack(irq_ack),
        .return_from_irq(return_from_irq), .irq_vector(irq_vector), .push_pc(push_pc));
    core_model partner (.sys_clk(sys_clk), .rst_n(rst_n), .irq_ack(irq_ack), .ret_en(ret_en),
        .ret_delay(ret_delay), .phase_two_tick(phase_two_tick),
        .return_from_irq(return_from_irq));
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_ack(input logic [7:0] exp);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (irq_ack !== 1'b1 && n < 300);
        check({22'h0, push_pc, irq_ack, irq_vector}, {22'h0, 2'h3, exp});
    endtask
    task automatic apply(input int k, input logic on);
        case (k)
            0: ext_irq_pin <= !on;
            1: tmr0_overflow <= on;
            2: tmr1_overflow <= on;
            3: rtc_tick <= on;
            4: hook_switch_in <= !on;
            5: hold_line_in <= !on;
            default: handsfree_in <= on;
        endcase
    endtask
    function automatic logic [15:0] exp_flag(input int k);
        case (k)
            0: return 16'h0010;
            1: return 16'h0020;
            2: return 16'h0040;
            3: return 16'h2000;
            default: return 16'h4000;
        endcase
    endfunction
    task automatic pin_event(input int k, input logic [15:0] exp);
        @(posedge sys_clk);
        apply(k, 1'b1);
        @(posedge sys_clk);
        apply(k, 1'b0);
        repeat (10) @(posedge sys_clk);
        apb(1'b0, PRI, 32'h0);
        check(rd, {24'h0, exp[7:0]});
        apb(1'b0, SEC, 32'h0);
        check(rd, {24'h0, exp[15:8]});
        apb(1'b1, PRI, 32'h0);
        apb(1'b1, SEC, 32'h0);
    endtask
    initial begin
        {rst_n, psel, penable, pwrite, stack_full, ret_en, idle_mode} = '0;
        {tmr0_overflow, tmr1_overflow, rtc_tick, handsfree_in, on_hook_status, hold_status} = '0;
        {ext_irq_pin, hook_switch_in, hold_line_in} = 3'h7;
        {paddr, pwdata, ret_delay} = '0;
        void'($urandom(76));
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        apb(1'b0, PRI, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, SEC, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        check({rd[30:0], err}, 32'h1);
        stack_full <= 1'b1;
        apb(1'b1, PRI, 32'hffffffff);
        apb(1'b1, SEC, 32'hffffffff);
        repeat (20) @(posedge sys_clk);
        apb(1'b0, PRI, 32'h0);
        check(rd, 32'h7f);
        apb(1'b0, SEC, 32'h0);
        check(rd, 32'h77);
        $display("test 1 done");
        ret_en <= 1'b1;
        stack_full <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            ret_delay <= 4'($urandom_range(2, 12));
            wait_ack(vecs[i]);
        end
        repeat (20) @(posedge sys_clk);
        $display("test 2 done");
        ret_en <= 1'b0;
        apb(1'b1, PRI, 32'h49);
        wait_ack(8'h0c);
        repeat (20) @(posedge sys_clk);
        apb(1'b0, PRI, 32'h0);
        check(rd, 32'h08);
        $display("test 3 done");
        apb(1'b1, PRI, 32'h0);
        apb(1'b1, SEC, 32'h0);
        for (int k = 0; k < 7; k++) pin_event(k, exp_flag(k));
        {on_hook_status, hold_status} <= 2'h3;
        pin_event(5, 16'h0);
        {on_hook_status, hold_status, idle_mode} <= 3'h1;
        pin_event(4, 16'h0);
        apb(1'b1, SEC, 32'h44);
        apb(1'b1, PRI, 32'h01);
        repeat (20) @(posedge sys_clk);
        apb(1'b0, SEC, 32'h0);
        check(rd, 32'h44);
        idle_mode <= 1'b0;
        wait_ack(8'h18);
        apb(1'b1, SEC, 32'h0);
        $display("test 4 done");
        for (int i = 0; i < 8; i++) begin
            d = $urandom;
            apb(1'b1, SEC, d);
            apb(1'b0, SEC, 32'h0);
            check(rd, d & 32'h77);
            apb(1'b1, PRI, d & 32'hfffffffe);
            apb(1'b0, PRI, 32'h0);
            check(rd, d & 32'h7e);
        end
        $display("test 5 done");
        end_of_test();
    end
endmodule
`default_nettype wire
